// *** vdp_consts.vh ***
/*
 * constants of the trellis datapath: opcode patterns, register offsets
 * of the bus slave, field positions and reset values.
 * assumes inclusion by vdp_datapath.v only; definitions only.
 */
`ifndef VDP_CONSTS_VH
`define VDP_CONSTS_VH

// first opcode words
`define VDP_OP_SEL_LOW_LD 16'he3fe
`define VDP_OP_STAGE 16'he526
`define VDP_OP_STAGE_BM 16'he280
`define VDP_OP_STAGE_LD16 16'he2c5
`define VDP_OP_SM_STORE 16'he20e
`define VDP_OP_SET_K 16'he6f2
`define VDP_OP_SM_INIT 16'hf2c5

// upper bits of the second opcode word
`define VDP_MSW_STAGE_BM 8'h02
`define VDP_MSW_STAGE_LD16 8'h03
`define VDP_MSW_SM_INIT 8'h01
`define VDP_MSW_PAIR_LD 3'h1
`define VDP_MSW_PAIR_ST 3'h0
`define VDP_MSW_SET_K 13'h0120

// legal select destinations
`define VDP_DEST_A0 4'h6
`define VDP_DEST_A1 4'h8
`define VDP_DEST_B0 4'h5
`define VDP_DEST_B1 4'h7

// bus register byte offsets
`define VDP_REG_CTRL 12'h000
`define VDP_REG_STATUS 12'h004
`define VDP_REG_IRQ_STS 12'h008
`define VDP_REG_IRQ_MASK 12'h00c
`define VDP_REG_TRANS_LO 12'h010
`define VDP_REG_TRANS_HI 12'h014
`define VDP_REG_SM_BASE 12'h100

// field positions
`define VDP_CTRL_CLIP_BIT 0
`define VDP_STS_OVF_BIT 0
`define VDP_STS_K_LSB 4
`define VDP_IRQ_OVF_BIT 0
`define VDP_IRQ_BADDEST_BIT 1

// reset values and responses
`define VDP_RST_WORD 32'h0000_0000
`define VDP_RST_K 3'h0
`define VDP_RESP_OKAY 2'h0
`define VDP_RESP_SLVERR 2'h2

`endif

// *** vdp_datapath.v ***
/*
 * trellis decoding datapath of the vector coprocessor: select-low with
 * parallel word load, full 32-butterfly stage (plain, with branch metric
 * calculation, with halfword load), paired metric load/store, constraint
 * length set, metric init; plus an axi4-lite slave for status and irq.
 * assumes the host pipeline presents one decoded instruction per cycle
 * with its memory operand, synchronous to core_clk.
 */
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
// Operation
// - select: pair a larger half, transition bit
// - select: pair b larger half, transition bit
// - select destinations only registers 6/8 and 5/7
// - select also loads load register from memory
// - select leaves status flags unchanged
// - full stage: 32 butterflies in one cycle
// - stage reads metrics, select config, branch metrics
// - stage writes 64 metrics, clipped when enabled
// - stage rewrites both transition registers
// - stage overflow sets flag regardless of clipping
// - stage with metric sum and difference load
// - stage with halfword load into register 0
// - paired load: high to odd, low to even
// - paired store: odd high, even low
// - set constraint length from 3-bit immediate
// - init: metric 0 zero, others from memory
// - moves, set and init keep flags
// - every instruction completes in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "vdp_consts.vh"

module vdp_datapath #(
  parameter ADDR_W = 12
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // instruction port from the host pipeline
  input wire op_valid,
  input wire [15:0] op_word0,
  input wire [15:0] op_word1,
  input wire [31:0] mem_rdata,
  // memory write data for the paired store
  output reg mem_wvalid_ff,
  output reg [31:0] mem_wdata_ff,
  // axi4-lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready_ff,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready_ff,
  output reg [1:0] s_axi_bresp_ff,
  output reg s_axi_bvalid_ff,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready_ff,
  output reg [31:0] s_axi_rdata_ff,
  output reg [1:0] s_axi_rresp_ff,
  output reg s_axi_rvalid_ff,
  input wire s_axi_rready,
  // interrupt
  output reg irq_ff
);

  localparam OP_NONE = 3'd0;
  localparam OP_SEL = 3'd1;
  localparam OP_STAGE = 3'd2;
  localparam OP_PAIR_LD = 3'd3;
  localparam OP_PAIR_ST = 3'd4;
  localparam OP_SET_K = 3'd5;
  localparam OP_INIT = 3'd6;

  // clip a 17-bit sum to 16 bits when enabled, else wrap
  function [15:0] vdp_clip;
    input [16:0] v;
    input en;
    begin
      if (en && (v[16] != v[15])) begin
        vdp_clip = v[16] ? 16'h8000 : 16'h7fff;
      end else begin
        vdp_clip = v[15:0];
      end
    end
  endfunction

  // opcode words to operation class; stage forms share one class
  function [2:0] vdp_decode;
    input [15:0] w0;
    input [15:0] w1;
    begin
      case (w0)
        `VDP_OP_SEL_LOW_LD: vdp_decode = OP_SEL;
        `VDP_OP_STAGE: vdp_decode = OP_STAGE;
        `VDP_OP_STAGE_BM: begin
          if (w1[15:13] == `VDP_MSW_PAIR_LD) begin
            vdp_decode = OP_PAIR_LD;
          end else if (w1[15:8] == `VDP_MSW_STAGE_BM) begin
            vdp_decode = OP_STAGE;
          end else begin
            vdp_decode = OP_NONE;
          end
        end
        `VDP_OP_STAGE_LD16: begin
          vdp_decode = (w1[15:8] == `VDP_MSW_STAGE_LD16) ? OP_STAGE : OP_NONE;
        end
        `VDP_OP_SM_STORE: begin
          vdp_decode = (w1[15:13] == `VDP_MSW_PAIR_ST) ? OP_PAIR_ST : OP_NONE;
        end
        `VDP_OP_SET_K: begin
          vdp_decode = (w1[15:3] == `VDP_MSW_SET_K) ? OP_SET_K : OP_NONE;
        end
        `VDP_OP_SM_INIT: begin
          vdp_decode = (w1[15:8] == `VDP_MSW_SM_INIT) ? OP_INIT : OP_NONE;
        end
        default: vdp_decode = OP_NONE;
      endcase
    end
  endfunction

  // architectural state
  reg [31:0] vr_ff [0:8];
  reg [15:0] sm_ff [0:63];
  reg [31:0] trans_lo_ff;
  reg [31:0] trans_hi_ff;
  reg clip_enable_ff;
  reg overflow_flag_ff;
  reg [2:0] constraint_len_ff;
  reg [1:0] irq_sts_ff;
  reg [1:0] irq_mask_ff;

  // bus holding registers
  reg [ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  wire [2:0] op_class = op_valid ? vdp_decode(op_word0, op_word1) : OP_NONE;
  wire [4:0] pair_idx = op_word1[12:8];
  wire [3:0] dest_a = op_word1[11:8];
  wire [3:0] dest_b = op_word1[15:12];

  // select destinations outside the legal pairs are refused
  wire dest_ok = ((dest_a == `VDP_DEST_A0) || (dest_a == `VDP_DEST_A1)) &&
                 ((dest_b == `VDP_DEST_B0) || (dest_b == `VDP_DEST_B1));

  // select: compare halves of both path pairs, signed
  wire sel_b_low = $signed(vr_ff[3][15:0]) > $signed(vr_ff[3][31:16]);
  wire sel_a_low = $signed(vr_ff[4][15:0]) > $signed(vr_ff[4][31:16]);
  wire [15:0] sel_b_val = sel_b_low ? vr_ff[3][15:0] : vr_ff[3][31:16];
  wire [15:0] sel_a_val = sel_a_low ? vr_ff[4][15:0] : vr_ff[4][31:16];

  // branch metric pair from the loaded word
  wire [15:0] bm_sum = mem_rdata[15:0] + mem_rdata[31:16];
  wire [15:0] bm_diff = mem_rdata[15:0] - mem_rdata[31:16];

  // full stage, all 32 butterflies combinational so it fits one cycle
  reg [1023:0] stage_sm;
  reg [31:0] stage_tlo;
  reg [31:0] stage_thi;
  reg stage_ovf;
  integer i;
  reg [127:0] bm_cfg;
  reg [15:0] bm;
  reg [16:0] p0;
  reg [16:0] p1;
  reg [16:0] q0;
  reg [16:0] q1;
  reg [16:0] win_lo;
  reg [16:0] win_hi;
  always @* begin
    stage_sm = 1024'h0;
    stage_tlo = 32'h0;
    stage_thi = 32'h0;
    stage_ovf = 1'b0;
    bm_cfg = {vr_ff[5], vr_ff[4], vr_ff[3], vr_ff[2]};
    bm = 16'h0;
    p0 = 17'h0;
    p1 = 17'h0;
    q0 = 17'h0;
    q1 = 17'h0;
    win_lo = 17'h0;
    win_hi = 17'h0;
    for (i = 0; i < 32; i = i + 1) begin
      // nibble per butterfly: [1:0] picks a metric half, [2] negates
      case (bm_cfg[4*i +: 2])
        2'h0: bm = vr_ff[0][15:0];
        2'h1: bm = vr_ff[0][31:16];
        2'h2: bm = vr_ff[1][15:0];
        default: bm = vr_ff[1][31:16];
      endcase
      if (bm_cfg[4*i+2]) begin
        bm = 16'h0 - bm;
      end
      p0 = {sm_ff[2*i][15], sm_ff[2*i]} + {bm[15], bm};
      p1 = {sm_ff[2*i+1][15], sm_ff[2*i+1]} - {bm[15], bm};
      q0 = {sm_ff[2*i][15], sm_ff[2*i]} - {bm[15], bm};
      q1 = {sm_ff[2*i+1][15], sm_ff[2*i+1]} + {bm[15], bm};
      win_lo = ($signed(p0) > $signed(p1)) ? p0 : p1;
      win_hi = ($signed(q0) > $signed(q1)) ? q0 : q1;
      stage_tlo[31-i] = ($signed(p0) > $signed(p1)) ? 1'b0 : 1'b1;
      stage_thi[31-i] = ($signed(q0) > $signed(q1)) ? 1'b0 : 1'b1;
      stage_sm[16*i +: 16] = vdp_clip(win_lo, clip_enable_ff);
      stage_sm[16*(i+32) +: 16] = vdp_clip(win_hi, clip_enable_ff);
      // overflow counted before clipping, whatever the clip setting
      if ((win_lo[16] != win_lo[15]) || (win_hi[16] != win_hi[15])) begin
        stage_ovf = 1'b1;
      end
    end
  end

  // metric window base at bus width, so the compare below is width-matched
  wire [ADDR_W-1:0] sm_base = `VDP_REG_SM_BASE;

  // bus read decode; metric window reads the live metrics
  reg [31:0] rd_data;
  reg rd_err;
  always @* begin
    rd_data = `VDP_RST_WORD;
    rd_err = 1'b0;
    if (s_axi_araddr[ADDR_W-1:8] == sm_base[ADDR_W-1:8]) begin
      rd_data = {16'h0, sm_ff[s_axi_araddr[7:2]]};
    end else begin
      case (s_axi_araddr)
        `VDP_REG_CTRL: rd_data[`VDP_CTRL_CLIP_BIT] = clip_enable_ff;
        `VDP_REG_STATUS: begin
          rd_data[`VDP_STS_OVF_BIT] = overflow_flag_ff;
          rd_data[`VDP_STS_K_LSB +: 3] = constraint_len_ff;
        end
        `VDP_REG_IRQ_STS: rd_data[1:0] = irq_sts_ff;
        `VDP_REG_IRQ_MASK: rd_data[1:0] = irq_mask_ff;
        `VDP_REG_TRANS_LO: rd_data = trans_lo_ff;
        `VDP_REG_TRANS_HI: rd_data = trans_hi_ff;
        default: rd_err = 1'b1;
      endcase
    end
  end

  wire wr_fire = !s_axi_awready_ff && !s_axi_wready_ff && !s_axi_bvalid_ff;
  wire wr_ok = (awaddr_ff == `VDP_REG_CTRL) || (awaddr_ff == `VDP_REG_STATUS) ||
               (awaddr_ff == `VDP_REG_IRQ_STS) || (awaddr_ff == `VDP_REG_IRQ_MASK);
  wire sw_clr_ovf = wr_fire && (awaddr_ff == `VDP_REG_STATUS) && wstrb_ff[0] &&
                    wdata_ff[`VDP_STS_OVF_BIT];
  wire [1:0] sw_clr_irq = (wr_fire && (awaddr_ff == `VDP_REG_IRQ_STS) && wstrb_ff[0]) ?
                          wdata_ff[1:0] : 2'h0;
  wire ev_ovf = (op_class == OP_STAGE) && stage_ovf;
  wire ev_bad = (op_class == OP_SEL) && !dest_ok;
  wire [1:0] irq_ev = {ev_bad, ev_ovf};
  wire [1:0] nxt_irq_sts = (irq_sts_ff & ~sw_clr_irq) | irq_ev;

  // one edge per instruction: all results land at the issuing edge
  integer k;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (k = 0; k < 9; k = k + 1) begin
        vr_ff[k] <= `VDP_RST_WORD;
      end
      for (k = 0; k < 64; k = k + 1) begin
        sm_ff[k] <= 16'h0;
      end
      trans_lo_ff <= `VDP_RST_WORD;
      trans_hi_ff <= `VDP_RST_WORD;
      constraint_len_ff <= `VDP_RST_K;
      mem_wvalid_ff <= 1'b0;
      mem_wdata_ff <= `VDP_RST_WORD;
    end else begin
      mem_wvalid_ff <= 1'b0;
      case (op_class)
        OP_SEL: begin
          if (dest_ok) begin
            trans_lo_ff <= {trans_lo_ff[30:0], ~sel_b_low};
            trans_hi_ff <= {trans_hi_ff[30:0], ~sel_a_low};
            vr_ff[dest_b][15:0] <= sel_b_val;
            vr_ff[dest_a][15:0] <= sel_a_val;
            vr_ff[2] <= mem_rdata;
          end
        end
        OP_STAGE: begin
          for (k = 0; k < 64; k = k + 1) begin
            sm_ff[k] <= stage_sm[16*k +: 16];
          end
          trans_lo_ff <= stage_tlo;
          trans_hi_ff <= stage_thi;
          if (op_word0 == `VDP_OP_STAGE_BM) begin
            vr_ff[0] <= {bm_diff, bm_sum};
          end else if (op_word0 == `VDP_OP_STAGE_LD16) begin
            vr_ff[0][15:0] <= mem_rdata[15:0];
          end
        end
        OP_PAIR_LD: begin
          sm_ff[{pair_idx, 1'b1}] <= mem_rdata[31:16];
          sm_ff[{pair_idx, 1'b0}] <= mem_rdata[15:0];
        end
        OP_PAIR_ST: begin
          mem_wvalid_ff <= 1'b1;
          mem_wdata_ff <= {sm_ff[{pair_idx, 1'b1}], sm_ff[{pair_idx, 1'b0}]};
        end
        OP_SET_K: constraint_len_ff <= op_word1[2:0];
        OP_INIT: begin
          sm_ff[0] <= 16'h0;
          for (k = 1; k < 64; k = k + 1) begin
            sm_ff[k] <= mem_rdata[15:0];
          end
        end
        default: mem_wvalid_ff <= 1'b0;
      endcase
    end
  end

  // flags and interrupt; only the stage may raise overflow, set beats clear
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overflow_flag_ff <= 1'b0;
      irq_sts_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      overflow_flag_ff <= ev_ovf | (overflow_flag_ff & ~sw_clr_ovf);
      irq_sts_ff <= nxt_irq_sts;
      irq_ff <= |(nxt_irq_sts & irq_mask_ff);
    end
  end

  // axi4-lite write: address and data taken in either order
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready_ff <= 1'b1;
      s_axi_wready_ff <= 1'b1;
      s_axi_bvalid_ff <= 1'b0;
      s_axi_bresp_ff <= `VDP_RESP_OKAY;
      awaddr_ff <= {ADDR_W{1'b0}};
      wdata_ff <= `VDP_RST_WORD;
      wstrb_ff <= 4'h0;
      clip_enable_ff <= 1'b0;
      irq_mask_ff <= 2'h0;
    end else begin
      if (s_axi_awready_ff && s_axi_awvalid) begin
        s_axi_awready_ff <= 1'b0;
        awaddr_ff <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wready_ff && s_axi_wvalid) begin
        s_axi_wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid_ff <= 1'b1;
        s_axi_bresp_ff <= wr_ok ? `VDP_RESP_OKAY : `VDP_RESP_SLVERR;
        if (awaddr_ff == `VDP_REG_CTRL && wstrb_ff[0]) begin
          clip_enable_ff <= wdata_ff[`VDP_CTRL_CLIP_BIT];
        end
        if (awaddr_ff == `VDP_REG_IRQ_MASK && wstrb_ff[0]) begin
          irq_mask_ff <= wdata_ff[1:0];
        end
      end
      // reopen both channels only after the response is taken
      if (s_axi_bvalid_ff && s_axi_bready) begin
        s_axi_bvalid_ff <= 1'b0;
        s_axi_awready_ff <= 1'b1;
        s_axi_wready_ff <= 1'b1;
      end
    end
  end

  // axi4-lite read: one outstanding, data registered at acceptance
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready_ff <= 1'b1;
      s_axi_rvalid_ff <= 1'b0;
      s_axi_rdata_ff <= `VDP_RST_WORD;
      s_axi_rresp_ff <= `VDP_RESP_OKAY;
    end else begin
      if (s_axi_arready_ff && s_axi_arvalid) begin
        s_axi_arready_ff <= 1'b0;
        s_axi_rvalid_ff <= 1'b1;
        s_axi_rdata_ff <= rd_err ? `VDP_RST_WORD : rd_data;
        s_axi_rresp_ff <= rd_err ? `VDP_RESP_SLVERR : `VDP_RESP_OKAY;
      end else if (s_axi_rvalid_ff && s_axi_rready) begin
        s_axi_rvalid_ff <= 1'b0;
        s_axi_arready_ff <= 1'b1;
      end
    end
  end

endmodule // vdp_datapath

`default_nettype wire

// *** vdp_datapath_monitor.sv ***
/* checker for the trellis datapath: paired store pulse and bus handshakes.
   assumes it is bound onto vdp_datapath, one core_clk domain, rst high. */
`timescale 1ns/1ps
`default_nettype none
module vdp_datapath_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // instruction port
  input wire logic op_valid,
  input wire logic [15:0] op_word0,
  input wire logic [15:0] op_word1,
  input wire logic mem_wvalid_ff,
  input wire logic [31:0] mem_wdata_ff,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready_ff,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready_ff,
  input wire logic [1:0] s_axi_bresp_ff,
  input wire logic s_axi_bvalid_ff,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready_ff,
  input wire logic [31:0] s_axi_rdata_ff,
  input wire logic s_axi_rvalid_ff,
  input wire logic s_axi_rready
);
  // paired store as decoded at the port
  wire logic st_req;
  assign st_req = op_valid && op_word0 == 16'he20e && op_word1[15:13] == 3'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_store_pulse: assert property (st_req |=> mem_wvalid_ff)
    else $error("store data not flagged one cycle after request");
  chk_store_only: assert property (!st_req |=> !mem_wvalid_ff)
    else $error("store valid without a store request");
  chk_wdata_held: assert property (!st_req |=> $stable(mem_wdata_ff))
    else $error("store data moved without a store");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready_ff && s_axi_wvalid
    && s_axi_wready_ff |-> ##[1:2] s_axi_bvalid_ff)
    else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid_ff && !s_axi_bready |=>
    s_axi_bvalid_ff && $stable(s_axi_bresp_ff))
    else $error("write response dropped before bready");
  chk_write_busy: assert property (s_axi_bvalid_ff |-> !s_axi_awready_ff && !s_axi_wready_ff)
    else $error("write accepted while response pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready_ff |=> s_axi_rvalid_ff)
    else $error("read data not one cycle after address");
  chk_rdata_hold: assert property (s_axi_rvalid_ff && !s_axi_rready |=>
    s_axi_rvalid_ff && $stable(s_axi_rdata_ff))
    else $error("read data dropped before rready");
  chk_read_busy: assert property (s_axi_rvalid_ff |-> !s_axi_arready_ff)
    else $error("read accepted while data pending");
endmodule // vdp_datapath_monitor
bind vdp_datapath vdp_datapath_monitor mon_u (.core_clk(core_clk), .rst(rst),
  .op_valid(op_valid), .op_word0(op_word0), .op_word1(op_word1),
  .mem_wvalid_ff(mem_wvalid_ff), .mem_wdata_ff(mem_wdata_ff),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready_ff(s_axi_awready_ff),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready_ff(s_axi_wready_ff),
  .s_axi_bresp_ff(s_axi_bresp_ff), .s_axi_bvalid_ff(s_axi_bvalid_ff),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready_ff(s_axi_arready_ff), .s_axi_rdata_ff(s_axi_rdata_ff),
  .s_axi_rvalid_ff(s_axi_rvalid_ff), .s_axi_rready(s_axi_rready));
`default_nettype wire

// *** vdp_datapath_tb.sv ***
/* self-checking bench: instruction sequences plus axi4-lite readback.
   assumes vdp_host_model drives the instruction port, clock 50 mhz. */
`timescale 1ns/1ps
`default_nettype none
module vdp_datapath_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid;
  logic [15:0] op_word0;
  logic [15:0] op_word1;
  logic [31:0] mem_rdata;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, irq, mwv;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, mwd;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  always #10 core_clk = ~core_clk;
  vdp_datapath dut_u (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
    .op_word0(op_word0), .op_word1(op_word1), .mem_rdata(mem_rdata),
    .mem_wvalid_ff(mwv), .mem_wdata_ff(mwd), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready_ff(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready_ff(wready),
    .s_axi_bresp_ff(bresp), .s_axi_bvalid_ff(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready_ff(arready),
    .s_axi_rdata_ff(rdata), .s_axi_rresp_ff(rresp), .s_axi_rvalid_ff(rvalid),
    .s_axi_rready(rready), .irq_ff(irq));
  vdp_host_model host_u (.core_clk(core_clk), .op_valid(op_valid), .op_word0(op_word0),
    .op_word1(op_word1), .mem_rdata(mem_rdata));
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  // address and data offered together, each dropped at its own ready
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1); // only the cycle guard ends a hung wait
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
    axr(a, rd, rr);
    cmp_word(nm, e, rd);
  endtask
  // metrics sit one word each from offset 0x100, low half only
  task automatic rd_sm(input logic [5:0] k, input logic [15:0] e, input string nm);
    axr({4'h1, k, 2'b00}, rd, rr);
    cmp_word(nm, {16'h0, e}, rd & 32'h0000_ffff);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well above the hundred or so cycles the sequence needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(12'h004, 32'h0, "status reset");
    axr(12'h020, rd, rr);
    cmp_word("unmapped resp", 32'h2, {30'h0, rr});
    host_u.issue(16'hf2c5, 16'h0100, 32'h0000_1234);
    rd_sm(6'd0, 16'h0000, "metric 0");
    rd_sm(6'd63, 16'h1234, "metric 63");
    host_u.issue(16'he280, 16'h2300, 32'haaaa_5555);
    rd_sm(6'd6, 16'h5555, "metric 6");
    rd_sm(6'd7, 16'haaaa, "metric 7");
    host_u.issue(16'he20e, 16'h0300, 32'h0);
    #1;
    cmp_bit("store valid", 1'b1, mwv);
    cmp_word("store data", 32'haaaa_5555, mwd);
    @(posedge core_clk);
    #1;
    cmp_bit("store pulse end", 1'b0, mwv);
    // legal select then one with a bad destination, which must be refused
    axw(12'h00c, 32'h2, rr);
    cmp_word("mask write resp", 32'h0, {30'h0, rr});
    axw(12'h030, 32'h1, rr);
    cmp_word("unmapped write resp", 32'h2, {30'h0, rr});
    host_u.issue(16'he3fe, 16'h5600, 32'h0000_0004);
    host_u.issue(16'he3fe, 16'h5500, 32'h0);
    rd_chk(12'h010, 32'h1, "trans low");
    rd_chk(12'h014, 32'h1, "trans high");
    rd_chk(12'h004, 32'h0, "status after select");
    rd_chk(12'h008, 32'h2, "irq status dest");
    cmp_bit("irq on", 1'b1, irq);
    axw(12'h008, 32'h2, rr);
    rd_chk(12'h008, 32'h0, "irq cleared");
    cmp_bit("irq off", 1'b0, irq);
    // stage with metric load, then a clipped stage that overflows
    host_u.issue(16'he280, 16'h0200, 32'h0001_7000);
    axw(12'h000, 32'h1, rr);
    host_u.issue(16'he526, 16'h0000, 32'h0);
    rd_sm(6'd1, 16'h7fff, "metric 1 clipped");
    rd_chk(12'h004, 32'h1, "overflow flag");
    axr(12'h010, rd, rr);
    cmp_bit("state 0 transition", 1'b1, rd[31]);
    rd_chk(12'h008, 32'h1, "irq status ovf");
    cmp_bit("irq masked", 1'b0, irq);
    host_u.issue(16'he6f2, 16'h0905, 32'h0);
    rd_chk(12'h004, 32'h51, "constraint length");
    host_u.issue(16'he2c5, 16'h0300, 32'hffff_0005);
    host_u.issue(16'hf2c5, 16'h0100, 32'h0000_1234);
    host_u.issue(16'he526, 16'h0000, 32'h0);
    rd_sm(6'd1, 16'h1239, "metric 1 after load");
    summarize();
  end
endmodule // vdp_datapath_tb
`default_nettype wire

// *** vdp_host_model.sv ***
/* host pipeline model: issues one instruction with its operand per call.
   assumes the caller runs on core_clk and waits for the call to return. */
`timescale 1ns/1ps
`default_nettype none
module vdp_host_model (
  // clock
  input wire logic core_clk,
  // instruction port
  output logic op_valid,
  output logic [15:0] op_word0,
  output logic [15:0] op_word1,
  output logic [31:0] mem_rdata
);
  initial begin
    op_valid = 1'b0;
    op_word0 = 16'h0000;
    op_word1 = 16'h0000;
    mem_rdata = 32'h0000_0000;
  end
  // valid and operand live for exactly the execution cycle; the words stay held
  task automatic issue(input logic [15:0] w0, input logic [15:0] w1, input logic [31:0] d);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_word0 <= w0;
    op_word1 <= w1;
    mem_rdata <= d;
    @(posedge core_clk);
    op_valid <= 1'b0;
    mem_rdata <= ~d; // stale operand inverted so a late read is caught
  endtask
endmodule // vdp_host_model
`default_nettype wire
